/* File: src/prom_prog_consts.vh */
`ifndef PROM_PROG_CONSTS_VH
`define PROM_PROG_CONSTS_VH

// ------------------------------------------------------------
// Clock and pulse timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      20
`define PW_MIN_NS          190000
`define PW_MAX_NS          210000
`define PW_TYP_NS          200000
`define OPW_MAX_NS         5250000
`define PW_CYCLES          ((`PW_TYP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPW_MAX_CYCLES     (`OPW_MAX_NS / `CLK_PERIOD_NS)
`define SETUP_NS           2000
`define SETUP_CYCLES       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUT_DELAY_NS       150
`define OUT_DELAY_CYCLES   ((`OUT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// Address space and limits
// ------------------------------------------------------------
`define ADDR_W             17
`define LAST_ADDR          17'h0FFFF
`define BLANK_BYTE         8'hFF
`define MAX_TRIES          5'h19
`define OVER_FACTOR        3

`endif

/* File: src/prom_byte_buf.v */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Image memory, registered read
// ------------------------------------------------------------
module prom_byte_buf (
  input  wire        ref_clk,
  input  wire        wr_en,
  input  wire [15:0] wr_addr,
  input  wire [7:0]  wr_data,
  input  wire [15:0] rd_addr,
  output reg  [7:0]  rd_data
);

  reg [7:0] mem [0:65535];

  always @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // prom_byte_buf

/* File: src/prom_byte_programmer.v */
`timescale 1ns/10ps
`include "prom_prog_consts.vh"

module prom_byte_programmer (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        load_en,
  input  wire [15:0] load_addr,
  input  wire [7:0]  load_data,
  input  wire        start,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output reg  [7:0]  data_oe,
  output reg  [16:0] addr_out,
  output reg         chip_sel_n,
  output reg         out_strobe_n,
  output reg         program_strobe_n,
  output reg         vpp_on,
  output reg         busy,
  output reg         done,
  output reg         fail,
  output reg  [16:0] fail_addr
);

  // ----------------------------------------------------------
  // States and timing
  // ----------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_FETCH = 4'h1;
  localparam [3:0] S_SETW  = 4'h2;
  localparam [3:0] S_PULSE = 4'h3;
  localparam [3:0] S_SETV  = 4'h4;
  localparam [3:0] S_READ  = 4'h5;
  localparam [3:0] S_OVER  = 4'h6;
  localparam [3:0] S_NEXT  = 4'h7;
  localparam [3:0] S_HOLD  = 4'h8;
  localparam [3:0] S_FIN   = 4'h9;

  localparam integer PW_CYC_I = `PW_CYCLES;
  localparam integer SU_CYC_I = `SETUP_CYCLES;
  localparam integer OD_CYC_I = `OUT_DELAY_CYCLES + 1;
  localparam [23:0]  PW_CYC   = PW_CYC_I[23:0];
  localparam [23:0]  SU_CYC   = SU_CYC_I[23:0];
  localparam [23:0]  OD_CYC   = OD_CYC_I[23:0];

  reg [3:0]  state_reg;
  reg [23:0] cnt_reg;
  reg [23:0] over_reg;
  reg [4:0]  tries_reg;
  reg        prev_bad_reg;
  reg [7:0]  want_reg;
  reg [7:0]  din_s1_reg;
  reg [7:0]  din_s2_reg;
  wire [7:0] img_byte;

  prom_byte_buf u_buf (
    .ref_clk (ref_clk),
    .wr_en   (load_en & ~busy),
    .wr_addr (load_addr),
    .wr_data (load_data),
    .rd_addr (addr_out[15:0]),
    .rd_data (img_byte)
  );

  // ----------------------------------------------------------
  // Data input synchroniser
  // ----------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
    end
    else
    begin
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  // ----------------------------------------------------------
  // Write/verify sequencer
  // ----------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg        <= S_IDLE;
      cnt_reg          <= 24'h000000;
      over_reg         <= 24'h000000;
      tries_reg        <= 5'h00;
      prev_bad_reg     <= 1'b0;
      want_reg         <= 8'h00;
      data_out         <= 8'h00;
      data_oe          <= 8'h00;
      addr_out         <= 17'h00000;
      chip_sel_n       <= 1'b1;
      out_strobe_n     <= 1'b1;
      program_strobe_n <= 1'b1;
      vpp_on           <= 1'b0;
      busy             <= 1'b0;
      done             <= 1'b0;
      fail             <= 1'b0;
      fail_addr        <= 17'h00000;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          chip_sel_n       <= 1'b1;
          out_strobe_n     <= 1'b1;
          program_strobe_n <= 1'b1;
          data_oe          <= 8'h00;
          if (start)
          begin
            busy         <= 1'b1;
            done         <= 1'b0;
            fail         <= 1'b0;
            prev_bad_reg <= 1'b0;
            addr_out     <= 17'h00000;
            vpp_on       <= 1'b1;
            state_reg    <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          state_reg <= S_HOLD;
        end
        S_HOLD:
        begin
          want_reg  <= img_byte;
          tries_reg <= 5'h00;
          if (img_byte == `BLANK_BYTE)
          begin
            state_reg <= S_NEXT;
          end
          else
          begin
            cnt_reg   <= 24'h000000;
            state_reg <= S_SETW;
          end
        end
        S_SETW:
        begin
          // Write mode: chip select low, output strobe high, data driven
          chip_sel_n   <= 1'b0;
          out_strobe_n <= 1'b1;
          data_out     <= want_reg;
          data_oe      <= 8'hFF;
          cnt_reg      <= cnt_reg + 24'h000001;
          if (cnt_reg == SU_CYC)
          begin
            cnt_reg          <= 24'h000000;
            program_strobe_n <= 1'b0;
            state_reg        <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          cnt_reg <= cnt_reg + 24'h000001;
          if (cnt_reg == over_reg)
          begin
            program_strobe_n <= 1'b1;
            cnt_reg          <= 24'h000000;
            state_reg        <= (tries_reg == 5'h1F) ? S_NEXT : S_SETV;
          end
        end
        S_SETV:
        begin
          // Release bus, then verify: output strobe low, program strobe high
          data_oe <= 8'h00;
          cnt_reg <= cnt_reg + 24'h000001;
          if (cnt_reg == SU_CYC)
          begin
            cnt_reg      <= 24'h000000;
            out_strobe_n <= 1'b0;
            state_reg    <= S_READ;
          end
        end
        S_READ:
        begin
          cnt_reg <= cnt_reg + 24'h000001;
          if (cnt_reg == OD_CYC)
          begin
            out_strobe_n <= 1'b1;
            cnt_reg      <= 24'h000000;
            tries_reg    <= tries_reg + 5'h01;
            if (din_s2_reg == want_reg)
            begin
              state_reg <= S_OVER;
            end
            else if (tries_reg + 5'h01 >= `MAX_TRIES)
            begin
              fail_addr <= addr_out;
              if (prev_bad_reg)
              begin
                fail      <= 1'b1;
                state_reg <= S_FIN;
              end
              else
              begin
                prev_bad_reg <= 1'b1;
                state_reg    <= S_NEXT;
              end
            end
            else
            begin
              state_reg <= S_SETW;
            end
          end
        end
        S_OVER:
        begin
          // Overprogram pulse: tries x factor x initial, capped
          prev_bad_reg <= 1'b0;
          over_reg     <= ovr_len(tries_reg);
          tries_reg    <= 5'h1F;
          state_reg    <= S_SETW;
        end
        S_NEXT:
        begin
          over_reg  <= PW_CYC - 24'h000001;
          data_oe   <= 8'h00;
          if (addr_out == `LAST_ADDR)
          begin
            state_reg <= S_FIN;
          end
          else
          begin
            addr_out  <= addr_out + 17'h00001;
            state_reg <= S_FETCH;
          end
        end
        S_FIN:
        begin
          chip_sel_n       <= 1'b1;
          out_strobe_n     <= 1'b1;
          program_strobe_n <= 1'b1;
          data_oe          <= 8'h00;
          vpp_on           <= 1'b0;
          busy             <= 1'b0;
          done             <= 1'b1;
          state_reg        <= S_IDLE;
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
      if (state_reg == S_IDLE)
      begin
        over_reg <= PW_CYC - 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------
  // Overprogram length in cycles, capped at max
  // ----------------------------------------------------------
  function [23:0] ovr_len;
    input [4:0] n;
    reg   [31:0] v;
    begin
      v = n * `OVER_FACTOR * `PW_CYCLES;
      if (v > `OPW_MAX_CYCLES)
      begin
        v = `OPW_MAX_CYCLES;
      end
      ovr_len = v[23:0] - 24'h000001;
    end
  endfunction

endmodule // prom_byte_programmer

/* File: dv/prom_device_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Byte-wide one-time PROM seen through the socket
// ------------------------------------------------------------
module prom_device_model #(
  parameter [15:0] WEAK_ADDR = 16'h0100
) (
  input  wire        chip_sel_n,
  input  wire        out_strobe_n,
  input  wire        program_strobe_n,
  input  wire        vpp_on,
  input  wire [16:0] addr,
  input  wire [7:0]  bus,
  output wire [7:0]  drive,
  output wire        drive_en
);
  reg  [7:0] mem [0:65535];
  reg  [7:0] last;
  reg        weak_hit;
  wire [7:0] stored;
  integer    i;
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = 8'hFF;
    last = 8'h00;
    weak_hit = 1'b0;
  end
  // Upper half reads blank
  assign stored = addr[16] ? 8'hFF : mem[addr[15:0]];
  // Verify drives; otherwise floating lines
  assign drive_en = !chip_sel_n && !out_strobe_n && program_strobe_n;
  assign drive = drive_en ? stored : ~last;
  always @*
    if (drive_en)
      last = stored;
  // One byte stored per write pulse; weak cell ignores its first pulse
  always @(negedge program_strobe_n)
    if (!chip_sel_n && out_strobe_n && vpp_on && !addr[16])
    begin
      if (addr[15:0] == WEAK_ADDR && !weak_hit)
        weak_hit <= 1'b1;
      else
        mem[addr[15:0]] <= mem[addr[15:0]] & bus;
    end
endmodule // prom_device_model

/* File: dv/prom_byte_programmer_properties.sv */
`timescale 1ns/10ps
module prom_byte_programmer_properties (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        start,
  input wire [7:0]  data_oe,
  input wire [16:0] addr_out,
  input wire        chip_sel_n,
  input wire        out_strobe_n,
  input wire        program_strobe_n,
  input wire        vpp_on,
  input wire        busy,
  input wire        done
);
  reg [19:0] low_cnt;
  always @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      low_cnt <= 20'h00000;
    else if (program_strobe_n)
      low_cnt <= 20'h00000;
    else
      low_cnt <= low_cnt + 20'h00001;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_write_levels: assert property (!program_strobe_n |-> !chip_sel_n &&
    out_strobe_n && vpp_on && data_oe == 8'hFF) else $error("bad write");
  a_verify_float: assert property (!out_strobe_n |-> program_strobe_n &&
    data_oe == 8'h00) else $error("bad verify");
  a_idle_safe: assert property (!busy && !$past(busy) |->
    program_strobe_n && !vpp_on) else $error("pins active idle");
  a_upper_unused: assert property (addr_out[16] == 1'b0)
    else $error("upper half addressed");
  a_pulse_width: assert property ($rose(program_strobe_n) |->
    low_cnt >= 20'h0251C && low_cnt <= 20'h40164) else $error("pulse width");
  a_pulse_cap: assert property (low_cnt <= 20'h40164)
    else $error("pulse too long");
  a_addr_steady: assert property (!program_strobe_n &&
    !$past(program_strobe_n) |-> $stable(addr_out)) else $error("addr moved");
  a_start_busy: assert property (start && !busy |=> busy)
    else $error("start not taken");
  a_done_idle: assert property (done |-> !busy)
    else $error("done while busy");
  c_pulse: cover property ($rose(program_strobe_n));
  c_verify: cover property ($fell(out_strobe_n));
  c_done: cover property ($rose(done));
endmodule // prom_byte_programmer_properties
bind prom_byte_programmer prom_byte_programmer_properties u_props (
  .ref_clk, .sys_rst, .start, .data_oe, .addr_out, .chip_sel_n,
  .out_strobe_n, .program_strobe_n, .vpp_on, .busy, .done);

/* File: dv/prom_byte_program_port_tb.sv */
`timescale 1ns/10ps
module prom_byte_program_port_tb;
  reg         ref_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         load_en = 1'b0;
  reg  [15:0] load_addr = 16'h0000;
  reg  [7:0]  load_data = 8'h00;
  reg         start = 1'b0;
  wire [7:0]  data_out, data_oe, dev_drive, bus;
  wire [16:0] addr_out, fail_addr;
  wire        chip_sel_n, out_strobe_n, program_strobe_n, vpp_on;
  wire        busy, done, fail, dev_en;
  integer     n_mismatch = 0, checks_done = 0, cycles = 0;
  integer     seed = 53744, i, k;
  integer     n_pulse = 0, n_prog = 0;
  reg  [7:0]  exp_mem [0:65535];
  assign bus = (data_out & data_oe) | (dev_drive & ~data_oe);
  always #10 ref_clk = ~ref_clk;
  prom_byte_programmer DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .start(start), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .addr_out(addr_out), .chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
    .program_strobe_n(program_strobe_n), .vpp_on(vpp_on), .busy(busy),
    .done(done), .fail(fail), .fail_addr(fail_addr));
  prom_device_model DEV (.chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
    .program_strobe_n(program_strobe_n), .vpp_on(vpp_on), .addr(addr_out),
    .bus(bus), .drive(dev_drive), .drive_en(dev_en));
  task check(input [31:0] seen, input [31:0] want);
  begin
    checks_done = checks_done + 1;
    if (seen !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 1000000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  always @(negedge program_strobe_n)
    n_pulse = n_pulse + 1;
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      exp_mem[i] = 8'hFF;
    for (k = 0; k < 4; k = k + 1)
      exp_mem[$random(seed) & 32'hFFFF] = $random(seed) & 32'h7F;
    exp_mem[0] = 8'h5A;
    exp_mem[16'h0100] = 8'h81;
    exp_mem[65535] = 8'h00;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 65536; i = i + 1)
    begin
      @(posedge ref_clk);
      load_en   <= 1'b1;
      load_addr <= i[15:0];
      load_data <= exp_mem[i];
    end
    @(posedge ref_clk);
    load_en <= 1'b0;
    start   <= 1'b1;
    @(posedge ref_clk);
    start   <= 1'b0;
    repeat (2) @(posedge ref_clk);
    load_en   <= 1'b1;
    load_addr <= 16'hFFFF;
    load_data <= 8'h3C;
    start     <= 1'b1;
    @(posedge ref_clk);
    load_en <= 1'b0;
    start   <= 1'b0;
    @(negedge ref_clk);
    check(busy, 1);
    while (done !== 1'b1)
      @(posedge ref_clk);
    @(negedge ref_clk);
    check(done, 1);
    check(busy, 0);
    check(fail, 0);
    check(fail_addr, 0);
    check(dev_en, 0);
    for (i = 0; i < 65536; i = i + 1)
    begin
      if (exp_mem[i] != 8'hFF)
        n_prog = n_prog + 1;
      check(DEV.mem[i], exp_mem[i]);
    end
    check(n_pulse, 2 * n_prog + 1);
    tally_and_finish;
  end
endmodule // prom_byte_program_port_tb
